/* File: core/drr_fifo.sv */
// Synchronous valid/ready FIFO with parameter width and depth
`timescale 1ns/10ps
`default_nettype none
module drr_fifo
#(
  parameter int WIDTH = 96,
  parameter int DEPTH = 32
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Status
  output logic full,
  output logic empty
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign full = (count == (AW+1)'(DEPTH));
  assign empty = (count == '0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: core/drr_pkg.sv */
// Package: register map, field layout and carriers for the data FIFO routing block
package drr_pkg;

  localparam int DRR_ADDR_W = 8;
  localparam int DRR_DATA_W = 32;
  localparam int DRR_OFFSET_W = 48;
  localparam int DRR_NODE_W = 16;

  // Register byte offsets
  localparam logic [7:0] DRR_OFF_DMA_CTRL = 8'h90;
  localparam logic [7:0] DRR_OFF_STATUS = 8'h94;
  localparam logic [7:0] DRR_OFF_TX_BLOCK = 8'hB4;
  localparam logic [7:0] DRR_OFF_TX_DEST_HI = 8'hB8;
  localparam logic [7:0] DRR_OFF_TX_DEST_LO = 8'hBC;
  localparam logic [7:0] DRR_OFF_RX_CTRL = 8'hC0;
  localparam logic [7:0] DRR_OFF_RX_WIDTH = 8'hC4;
  localparam logic [7:0] DRR_OFF_RX_DEST_HI = 8'hC8;
  localparam logic [7:0] DRR_OFF_RX_DEST_LO = 8'hCC;

  // Field positions
  localparam int DRR_DMA_LONG_BLOCK_BIT = 0;
  localparam int DRR_DMA_PKTZ_BIT = 1;
  localparam int DRR_ST_NODE_VALID_BIT = 0;
  localparam int DRR_ST_FIFO_FULL_BIT = 1;
  localparam int DRR_ST_FIFO_EMPTY_BIT = 2;
  localparam int DRR_RX_BUS_ID_EN_BIT = 0;
  localparam int DRR_RX_SRC_ID_EN_BIT = 1;
  localparam int DRR_RX_ADDR_EN_BIT = 2;
  localparam int DRR_RX_CTRL_W = 3;
  localparam int DRR_TX_NODE_LSB = 0;
  localparam int DRR_TX_NODE_W = 16;
  localparam int DRR_TX_OFFHI_LSB = 16;
  localparam int DRR_TX_OFFHI_W = 16;
  localparam int DRR_RX_NODE_LSB = 0;
  localparam int DRR_RX_NODE_W = 17;
  localparam int DRR_RX_OFFHI_LSB = 17;
  localparam int DRR_RX_OFFHI_W = 15;
  // Source ID layout: bus number above, node number below
  localparam int DRR_PHY_NODE_W = 6;

  // Reset values
  localparam logic [31:0] DRR_RESET_WORD = 32'h0000_0000;
  localparam logic [2:0] DRR_RX_CTRL_RESET = 3'h0;

  localparam int DRR_FIFO_DEPTH = 32;

  // Received write request as it arrives from the link
  typedef struct packed {
    logic [DRR_NODE_W-1:0] source_id;
    logic [DRR_OFFSET_W-1:0] dest_offset;
    logic [DRR_DATA_W-1:0] payload;
  } drr_wreq_t;

  // Transmit destination as presented to the transmitter
  typedef struct packed {
    logic [DRR_NODE_W-1:0] node;
    logic [DRR_OFFSET_W-1:0] offset;
  } drr_tx_dest_t;

  typedef enum logic [1:0] {
    DRR_BUS_IDLE = 2'h1,
    DRR_BUS_ANSWER = 2'h2
  } drr_bus_state_t;

endpackage

/* File: core/drr_routing_top.sv */
// Transmit destination registers and receive write-request routing
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1: Block register is a byte size when long-block is 1, else a block count.
// R2: In count mode the count drops by one per transmitted block.
// R3: Block register resets to zero and is forced to zero on bus reset.
// R4: Transmit node in bits 0-15, offset high in bits 16-31 of one register.
// R5: Separate 32-bit register holds the transmit offset low part.
// R6: Receive registers act in direct mode while packetizer select is 0.
// R7: Receive control registers reset to zero and survive bus reset.
// R8: With address routing on, window hits go to the receive data FIFO.
// R9: Bit 0 enables bus ID check, effective only with address routing.
// R10: Bit 1 enables source ID check, effective only with address routing.
// R11: Source mismatch goes to async queue only when source check is on.
// R12: Window misses, or routing off, go to the async receive queue.
// R13: A 32-bit width register sets the depth of the receive window.
// R14: Receive node in bits 0-16, offset high in bits 17-31.
// R15: A 32-bit register holds the receive start offset low part.
// R16: Writing transmit node sets node-valid; bus reset clears it.
// R17: Hit means start offset <= address < start offset plus width.
// R18: ID checks compare packet source ID fields to receive node field.
module drr_routing_top
  import drr_pkg::*;
#(
  parameter int FIFO_DEPTH = DRR_FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM register slave
  input wire logic [DRR_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DRR_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DRR_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Link events
  input wire logic bus_reset,
  input wire logic tx_block_done,
  // Transmit side view
  output logic [DRR_DATA_W-1:0] tx_block_value,
  output logic tx_block_is_size,
  output drr_tx_dest_t tx_dest,
  output logic tx_node_valid_flag,
  // Received write requests
  input wire logic rx_valid,
  output logic rx_ready,
  input wire drr_wreq_t rx_req,
  // Receive data FIFO output
  output logic rdf_valid,
  input wire logic rdf_ready,
  output drr_wreq_t rdf_req,
  // Async receive queue output
  output logic arq_valid,
  input wire logic arq_ready,
  output drr_wreq_t arq_req
);

  // Byte-lane merge used by every writable register except the DMA and receive control registers
  function automatic logic [31:0] drr_merge(input logic [31:0] old_value,
                                            input logic [31:0] new_value,
                                            input logic [3:0] lanes);
    logic [31:0] result;
    result = old_value;
    for (int i = 0; i < 4; i++)
    begin
      if (lanes[i])
      begin
        result[8*i +: 8] = new_value[8*i +: 8];
      end
    end
    return result;
  endfunction

  drr_bus_state_t bus_state;
  logic [DRR_DATA_W-1:0] next_readdata;
  logic wr_fire;
  logic rd_hit;

  logic long_block_select;
  logic rx_packetizer_select;
  logic [DRR_DATA_W-1:0] tx_block_counter;
  logic [DRR_DATA_W-1:0] tx_dest_hi_reg;
  logic [DRR_DATA_W-1:0] tx_target_offset_low;
  logic [DRR_RX_CTRL_W-1:0] rx_route_ctrl;
  logic [DRR_DATA_W-1:0] rx_window_depth;
  logic [DRR_DATA_W-1:0] rx_dest_hi_reg;
  logic [DRR_DATA_W-1:0] rx_target_offset_low;

  logic wr_dma;
  logic wr_tx_block;
  logic wr_tx_hi;
  logic wr_tx_lo;
  logic wr_rx_ctrl;
  logic wr_rx_width;
  logic wr_rx_hi;
  logic wr_rx_lo;

  logic fifo_full;
  logic fifo_empty;
  logic fifo_in_ready;
  logic fifo_in_valid;

  // One wait cycle: readdata is latched in the first cycle and offered in the second
  assign avs_waitrequest = (avs_read || avs_write) && (bus_state != DRR_BUS_ANSWER);
  assign wr_fire = avs_write && (bus_state == DRR_BUS_ANSWER);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_state <= DRR_BUS_IDLE;
    end
    else
    begin
      unique case (bus_state)
        DRR_BUS_IDLE:
        begin
          if (avs_read || avs_write)
          begin
            bus_state <= DRR_BUS_ANSWER;
          end
        end
        DRR_BUS_ANSWER:
        begin
          bus_state <= DRR_BUS_IDLE;
        end
        default:
        begin
          bus_state <= DRR_BUS_IDLE;
        end
      endcase
    end
  end

  assign wr_dma = wr_fire && (avs_address == DRR_OFF_DMA_CTRL);
  assign wr_tx_block = wr_fire && (avs_address == DRR_OFF_TX_BLOCK);
  assign wr_tx_hi = wr_fire && (avs_address == DRR_OFF_TX_DEST_HI);
  assign wr_tx_lo = wr_fire && (avs_address == DRR_OFF_TX_DEST_LO);
  assign wr_rx_ctrl = wr_fire && (avs_address == DRR_OFF_RX_CTRL);
  assign wr_rx_width = wr_fire && (avs_address == DRR_OFF_RX_WIDTH);
  assign wr_rx_hi = wr_fire && (avs_address == DRR_OFF_RX_DEST_HI);
  assign wr_rx_lo = wr_fire && (avs_address == DRR_OFF_RX_DEST_LO);

  // Unmapped addresses read as zero and ignore writes
  always_comb
  begin
    next_readdata = DRR_RESET_WORD;
    rd_hit = 1'b1;
    unique case (avs_address)
      DRR_OFF_DMA_CTRL:
      begin
        next_readdata[DRR_DMA_LONG_BLOCK_BIT] = long_block_select;
        next_readdata[DRR_DMA_PKTZ_BIT] = rx_packetizer_select;
      end
      DRR_OFF_STATUS:
      begin
        next_readdata[DRR_ST_NODE_VALID_BIT] = tx_node_valid_flag;
        next_readdata[DRR_ST_FIFO_FULL_BIT] = fifo_full;
        next_readdata[DRR_ST_FIFO_EMPTY_BIT] = fifo_empty;
      end
      DRR_OFF_TX_BLOCK: next_readdata = tx_block_counter;
      DRR_OFF_TX_DEST_HI: next_readdata = tx_dest_hi_reg;
      DRR_OFF_TX_DEST_LO: next_readdata = tx_target_offset_low;
      DRR_OFF_RX_CTRL: next_readdata[DRR_RX_CTRL_W-1:0] = rx_route_ctrl;
      DRR_OFF_RX_WIDTH: next_readdata = rx_window_depth;
      DRR_OFF_RX_DEST_HI: next_readdata = rx_dest_hi_reg;
      DRR_OFF_RX_DEST_LO: next_readdata = rx_target_offset_low;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      avs_readdata <= DRR_RESET_WORD;
    end
    else if (avs_read && bus_state == DRR_BUS_IDLE)
    begin
      avs_readdata <= rd_hit ? next_readdata : DRR_RESET_WORD;
    end
  end

  // Mode bits that live outside this block's documented registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      long_block_select <= 1'b0;
      rx_packetizer_select <= 1'b0;
    end
    else if (wr_dma && avs_byteenable[0])
    begin
      long_block_select <= avs_writedata[DRR_DMA_LONG_BLOCK_BIT];
      rx_packetizer_select <= avs_writedata[DRR_DMA_PKTZ_BIT];
    end
  end

  // Bus reset beats a same-cycle software write so the link never sees stale counts
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_block_counter <= DRR_RESET_WORD; // R3
    end
    else if (bus_reset)
    begin
      tx_block_counter <= DRR_RESET_WORD; // R3
    end
    else if (wr_tx_block)
    begin
      tx_block_counter <= drr_merge(tx_block_counter, avs_writedata, avs_byteenable);
    end
    else if (tx_block_done && !long_block_select && tx_block_counter != DRR_RESET_WORD)
    begin
      tx_block_counter <= tx_block_counter - 1'b1; // R2
    end
  end

  assign tx_block_value = tx_block_counter;
  assign tx_block_is_size = long_block_select; // R1

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_dest_hi_reg <= DRR_RESET_WORD;
      tx_target_offset_low <= DRR_RESET_WORD;
    end
    else
    begin
      if (wr_tx_hi)
      begin
        tx_dest_hi_reg <= drr_merge(tx_dest_hi_reg, avs_writedata, avs_byteenable); // R4
      end
      if (wr_tx_lo)
      begin
        tx_target_offset_low <= drr_merge(tx_target_offset_low, avs_writedata,
                                          avs_byteenable); // R5
      end
    end
  end

  assign tx_dest.node = tx_dest_hi_reg[DRR_TX_NODE_LSB +: DRR_TX_NODE_W]; // R4
  assign tx_dest.offset = {tx_dest_hi_reg[DRR_TX_OFFHI_LSB +: DRR_TX_OFFHI_W],
                           tx_target_offset_low}; // R5

  // A write touching the node field wins over a same-cycle bus reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_node_valid_flag <= 1'b0;
    end
    else if (wr_tx_hi && (avs_byteenable[0] || avs_byteenable[1]))
    begin
      tx_node_valid_flag <= 1'b1; // R16
    end
    else if (bus_reset)
    begin
      tx_node_valid_flag <= 1'b0; // R16
    end
  end

  // Receive registers ignore bus reset entirely
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_route_ctrl <= DRR_RX_CTRL_RESET; // R7
      rx_window_depth <= DRR_RESET_WORD; // R7
      rx_dest_hi_reg <= DRR_RESET_WORD; // R7
      rx_target_offset_low <= DRR_RESET_WORD; // R7
    end
    else
    begin
      if (wr_rx_ctrl && avs_byteenable[0])
      begin
        rx_route_ctrl <= avs_writedata[DRR_RX_CTRL_W-1:0];
      end
      if (wr_rx_width)
      begin
        rx_window_depth <= drr_merge(rx_window_depth, avs_writedata, avs_byteenable); // R13
      end
      if (wr_rx_hi)
      begin
        rx_dest_hi_reg <= drr_merge(rx_dest_hi_reg, avs_writedata, avs_byteenable); // R14
      end
      if (wr_rx_lo)
      begin
        rx_target_offset_low <= drr_merge(rx_target_offset_low, avs_writedata,
                                          avs_byteenable); // R15
      end
    end
  end

  // Routing decision
  logic address_routing_enable;
  logic source_id_check_enable;
  logic bus_id_check_enable;
  logic [DRR_RX_NODE_W-1:0] rx_target_node;
  logic [DRR_OFFSET_W:0] win_start;
  logic [DRR_OFFSET_W:0] win_end;
  logic [DRR_OFFSET_W:0] req_addr;
  logic win_hit;
  logic src_match;
  logic bus_match;
  logic to_fifo;

  // Packetizer mode is handled elsewhere; here it simply disables direct routing
  assign address_routing_enable = rx_route_ctrl[DRR_RX_ADDR_EN_BIT] && !rx_packetizer_select; // R6 R8
  assign source_id_check_enable = rx_route_ctrl[DRR_RX_SRC_ID_EN_BIT]; // R10
  assign bus_id_check_enable = rx_route_ctrl[DRR_RX_BUS_ID_EN_BIT]; // R9
  assign rx_target_node = rx_dest_hi_reg[DRR_RX_NODE_LSB +: DRR_RX_NODE_W]; // R14

  // Start is 47 bits wide; one extra bit keeps start plus width from wrapping
  assign win_start = (DRR_OFFSET_W+1)'({rx_dest_hi_reg[DRR_RX_OFFHI_LSB +: DRR_RX_OFFHI_W],
                                        rx_target_offset_low}); // R15
  assign win_end = win_start + (DRR_OFFSET_W+1)'(rx_window_depth); // R13
  assign req_addr = (DRR_OFFSET_W+1)'(rx_req.dest_offset);
  assign win_hit = (req_addr >= win_start) && (req_addr < win_end); // R17

  assign src_match = rx_req.source_id[DRR_PHY_NODE_W-1:0]
                     == rx_target_node[DRR_PHY_NODE_W-1:0]; // R18
  assign bus_match = rx_req.source_id[DRR_NODE_W-1:DRR_PHY_NODE_W]
                     == rx_target_node[DRR_NODE_W-1:DRR_PHY_NODE_W]; // R18

  assign to_fifo = address_routing_enable && win_hit // R8 R12
                   && (!source_id_check_enable || src_match) // R11
                   && (!bus_id_check_enable || bus_match); // R9

  // Back-pressure from either destination stalls the link side
  assign fifo_in_valid = rx_valid && to_fifo;
  assign rx_ready = to_fifo ? fifo_in_ready : (!arq_valid || arq_ready);

  drr_fifo #(
    .WIDTH($bits(drr_wreq_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_data_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(rx_req),
    .out_valid(rdf_valid),
    .out_ready(rdf_ready),
    .out_data(rdf_req),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // Async queue output stage
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arq_valid <= 1'b0;
      arq_req <= '0;
    end
    else if (!arq_valid || arq_ready)
    begin
      arq_valid <= rx_valid && !to_fifo; // R12
      arq_req <= rx_req;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_bus_request;
    (avs_read || avs_write) && bus_state == DRR_BUS_IDLE;
  endsequence

  sequence s_bus_answer;
    !avs_waitrequest;
  endsequence

  a_bus_one_wait: assert property (s_bus_request |-> avs_waitrequest ##1 s_bus_answer)
    else $error("bus answer not given on second cycle");

  a_block_bus_reset: assert property (bus_reset |=> tx_block_counter == DRR_RESET_WORD) // R3
    else $error("block register not cleared by bus reset");

  a_block_count_down: assert property (tx_block_done && !long_block_select && !bus_reset // R2
      && !wr_tx_block && tx_block_counter != DRR_RESET_WORD
      |=> tx_block_counter == $past(tx_block_counter) - 1'b1)
    else $error("block count did not decrement");

  a_block_size_hold: assert property (long_block_select && !bus_reset && !wr_tx_block // R1
      |=> $stable(tx_block_counter))
    else $error("block size changed without a write");

  a_node_valid_set: assert property (wr_tx_hi && avs_byteenable[0] // R16
      |=> tx_node_valid_flag ##1 (tx_node_valid_flag || $past(bus_reset)))
    else $error("node valid flag not set by node write");

  a_node_valid_clear: assert property (bus_reset && !wr_tx_hi |=> !tx_node_valid_flag) // R16
    else $error("node valid flag not cleared by bus reset");

  a_rx_regs_keep: assert property (bus_reset && !wr_fire // R7
      |=> $stable(rx_route_ctrl) && $stable(rx_window_depth) && $stable(rx_dest_hi_reg))
    else $error("receive registers disturbed by bus reset");

  a_route_off_async: assert property (rx_valid && rx_ready // R12
      && (!rx_route_ctrl[DRR_RX_ADDR_EN_BIT] || rx_packetizer_select || !win_hit)
      |=> arq_valid && arq_req == $past(rx_req))
    else $error("request not sent to async queue");

  a_route_src_check: assert property (rx_valid && address_routing_enable // R11
      && source_id_check_enable && !src_match |-> !fifo_in_valid)
    else $error("source mismatch reached data fifo");

  a_route_window: assert property (fifo_in_valid |-> req_addr >= win_start // R17
      && req_addr < win_start + (DRR_OFFSET_W+1)'(rx_window_depth))
    else $error("window miss reached data fifo");

endmodule
`default_nettype wire

/* File: verif/drr_remote_node.sv */
// Remote link node: sends write requests and drains both receive outputs
`timescale 1ns/10ps
`default_nettype none
module drr_remote_node
  import drr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bench control
  input wire logic hold_rdf,
  // Request side
  output logic rx_valid,
  input wire logic rx_ready,
  output drr_wreq_t rx_req,
  // Drain side
  output logic rdf_ready,
  output logic arq_ready
);
  drr_wreq_t q[$];
  function automatic void push(drr_wreq_t r);
    q.push_back(r);
  endfunction
  initial
  begin
    rx_valid = 1'b0;
    rx_req = '0;
    rdf_ready = 1'b0;
    arq_ready = 1'b0;
  end
  always @(posedge clk)
  begin
    // Random stalls so both outputs must hold their word
    rdf_ready <= !hold_rdf && ($urandom % 4 != 0);
    arq_ready <= ($urandom % 3 != 0);
    if (!reset_n)
      rx_valid <= 1'b0;
    else if (!rx_valid || rx_ready)
    begin
      if (q.size() > 0)
      begin
        rx_valid <= 1'b1;
        rx_req <= q.pop_front();
      end
      else
      begin
        rx_valid <= 1'b0;
        // Released word changes so no stale value looks valid
        rx_req <= ~rx_req;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the transmit registers and receive routing
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import drr_pkg::*;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest, bus_reset, tx_block_done;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, tx_block_value, d;
  logic [3:0] avs_byteenable;
  logic tx_block_is_size, tx_node_valid_flag, rx_valid, rx_ready, rdf_valid, rdf_ready;
  logic arq_valid, arq_ready, hold_rdf;
  drr_tx_dest_t tx_dest;
  drr_wreq_t rx_req, rdf_req, arq_req;
  drr_wreq_t e_rdf[$], e_arq[$];
  logic [2:0] m_ctl;
  logic [31:0] m_w, m_hi, m_lo;
  bit m_pktz;
  int n_errors, samples_checked;

  drr_routing_top #(.FIFO_DEPTH(32)) uut (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bus_reset(bus_reset), .tx_block_done(tx_block_done), .tx_block_value(tx_block_value),
    .tx_block_is_size(tx_block_is_size), .tx_dest(tx_dest),
    .tx_node_valid_flag(tx_node_valid_flag), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_req(rx_req), .rdf_valid(rdf_valid), .rdf_ready(rdf_ready), .rdf_req(rdf_req),
    .arq_valid(arq_valid), .arq_ready(arq_ready), .arq_req(arq_req));
  drr_remote_node p (.clk(clk), .reset_n(reset_n), .hold_rdf(hold_rdf),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_req(rx_req),
    .rdf_ready(rdf_ready), .arq_ready(arq_ready));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task end_sim;
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Request held until the rising edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    chk(avs_waitrequest, 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Write lands on this edge; callers look at outputs once settled
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, 4'hF);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(d, exp);
  endtask

  task automatic pulse(input bit rst, input int n);
    repeat (n)
    begin
      @(posedge clk);
      if (rst) bus_reset <= 1'b1;
      else tx_block_done <= 1'b1;
      @(posedge clk);
      bus_reset <= 1'b0;
      tx_block_done <= 1'b0;
      @(negedge clk);
    end
  endtask

  task automatic cfg(input logic [2:0] c, input logic [31:0] w, hi, lo);
    wr(8'hC0, {29'h0, c});
    wr(8'hC4, w);
    wr(8'hC8, hi);
    wr(8'hCC, lo);
    m_ctl = c;
    m_w = w;
    m_hi = hi;
    m_lo = lo;
  endtask

  function automatic bit to_fifo(drr_wreq_t r);
    logic [48:0] s;
    s = {2'b00, m_hi[31:17], m_lo};
    if (m_pktz || !m_ctl[2]) return 0;
    if ({1'b0, r.dest_offset} < s || {1'b0, r.dest_offset} >= s + m_w) return 0;
    if (m_ctl[1] && r.source_id[5:0] != m_hi[5:0]) return 0;
    if (m_ctl[0] && r.source_id[15:6] != m_hi[15:6]) return 0;
    return 1;
  endfunction

  // Kinds: 0 hit, 1 source miss, 2 first address past window, 3 bus miss, 4 last hit
  task automatic send(input int k);
    drr_wreq_t r;
    r.payload = $urandom;
    r.source_id = m_hi[15:0] ^ (k == 1 ? 16'h0001 : k == 3 ? 16'h0040 : 16'h0000);
    r.dest_offset = {1'b0, m_hi[31:17], m_lo} + (k == 2 ? m_w : k == 4 ? m_w - 1 : $urandom % m_w);
    if (to_fifo(r)) e_rdf.push_back(r);
    else e_arq.push_back(r);
    p.push(r);
  endtask

  task automatic drain;
    int n;
    n = 0;
    while ((e_rdf.size() > 0 || e_arq.size() > 0) && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk(n < 3000, 1'b1);
  endtask

  always @(posedge clk)
  begin
    if (reset_n && rdf_valid === 1'b1 && rdf_ready)
    begin
      if (e_rdf.size() > 0) chk(rdf_req, e_rdf.pop_front());
      else chk(1'b1, 1'b0);
    end
    if (reset_n && arq_valid === 1'b1 && arq_ready)
    begin
      if (e_arq.size() > 0) chk(arq_req, e_arq.pop_front());
      else chk(1'b1, 1'b0);
    end
  end

  initial
  begin
    repeat (80000) @(posedge clk);
    n_errors++;
    $display("mismatch at %0t: timeout", $time);
    end_sim();
  end

  initial
  begin
    {reset_n, avs_read, avs_write, bus_reset, tx_block_done, hold_rdf} = '0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    m_pktz = 0;
    void'($urandom(42));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 8'hB4; a <= 8'hCC; a += 4) rdc(a[7:0], 32'h0000_0000);
    rdc(8'h94, 32'h0000_0004);
    wr(8'h00, 32'hFFFF_FFFF);
    rdc(8'h00, 32'h0000_0000);
    wr(8'hB8, 32'hBEEF_1234);
    wr(8'hBC, 32'hCAFE_0001);
    chk(tx_dest, {16'h1234, 16'hBEEF, 32'hCAFE_0001});
    chk(tx_node_valid_flag, 1'b1);
    bus(1'b1, 8'hB8, 32'h5555_AAAA, 4'h4);
    rdc(8'hB8, 32'hBE55_1234);
    rdc(8'hBC, 32'hCAFE_0001);
    wr(8'hB4, 32'h0000_0005);
    pulse(0, 3);
    chk({tx_block_is_size, tx_block_value}, 33'h0_0000_0002);
    wr(8'h90, 32'h0000_0001);
    pulse(0, 2);
    chk({tx_block_is_size, tx_block_value}, 33'h1_0000_0002);
    wr(8'h90, 32'h0000_0000);
    pulse(0, 3);
    chk(tx_block_value, 32'h0000_0000);
    wr(8'hB4, 32'h0000_0007);
    cfg(3'h7, 32'h0000_0040, 32'h2468_ACE1, 32'h1357_9BDF);
    pulse(1, 1);
    chk({tx_node_valid_flag, tx_block_value}, 33'h0);
    rdc(8'hC0, 32'h0000_0007);
    rdc(8'hC8, 32'h2468_ACE1);
    rdc(8'hCC, 32'h1357_9BDF);
    wr(8'hC0, 32'hFFFF_FFFF);
    rdc(8'hC0, 32'h0000_0007);
    for (int c = 0; c < 8; c++)
    begin
      cfg(c[2:0], 32'h10 + $urandom % 256, $urandom, $urandom);
      for (int k = 0; k < 10; k++) send(k % 5);
      drain();
    end
    wr(8'h90, 32'h0000_0002);
    m_pktz = 1;
    for (int k = 0; k < 5; k++) send(0);
    drain();
    wr(8'h90, 32'h0000_0000);
    m_pktz = 0;
    cfg(3'h4, 32'h0000_1000, 32'h0002_0000, 32'h0000_0100);
    hold_rdf <= 1'b1;
    for (int k = 0; k < 36; k++) send(0);
    repeat (200) @(posedge clk);
    bus(1'b0, 8'h94, 32'h0000_0000, 4'hF);
    chk(d[2:1], 2'b01);
    @(negedge clk);
    chk({rx_valid, rx_ready}, 2'b10);
    hold_rdf <= 1'b0;
    drain();
    repeat (4) @(posedge clk);
    bus(1'b0, 8'h94, 32'h0000_0000, 4'hF);
    chk(d[2:1], 2'b10);
    end_sim();
  end
endmodule
`default_nettype wire
